/* File: design/srap_device.sv */
// Device end: serial register access port with its register bank.
// Assumes the link pins come from another clock domain and that the
// master clock runs at least several times faster than the link clock.
`include "srap_params.svh"
`default_nettype none

// What this block does
// - Reset then chip-select fall enters command phase.
// - Command byte: direction top bit, 5-bit address.
// - Direction bit one means register write.
// - Direction bit zero means register read.
// - Finished transfer returns to command phase.
// - Finished after register's least significant bit moves.
// - Data in sampled on clock falling edges.
// - Data out changes on clock rising edges.
// - Chip-select fall resets port, drops partial transfer.
// - Host keeps chip-select low whole transfer.
// - Chip-select rise aborts, floats data out.
// - Tied-low select: host completes every transfer.
// - Write data captured from fall after command.
// - Next write byte ends 4 us later.
// - Aborted partial write byte never updates register.
// - Registers one or two bytes; first byte is upper.
// - Write data right-justified; excess upper bits ignored.
// - Read drives first bit on next rising edge.
// - Read snapshots whole register before shifting.
// - Read floats data out at last falling edge.
module srap_device
  import srap_pkg::*;
#(
  // Per-register width minus one, four bits per address, address 0 lowest.
  parameter logic [`SRAP_NUM_REGS*`SRAP_WCODE_BITS-1:0] REG_WCODE =
    {`SRAP_NUM_REGS{4'hF}}
) (
  // Master clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Serial link
  srap_if.device           link,
  // Internal register updates from the device's own logic
  input  wire logic        upd_en,
  input  wire logic [4:0]  upd_addr,
  input  wire logic [15:0] upd_data,
  // Notice of each serial write into the bank
  output logic             wr_pulse,
  output logic      [4:0]  wr_addr,
  output logic      [15:0] wr_data
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic din_s1, din_s2;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_s3   <= 1'b1;
      din_s1  <= 1'b0;
      din_s2  <= 1'b0;
    end else if (ce) begin
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= link.cs_n;
      cs_s2   <= cs_s1;
      cs_s3   <= cs_s2;
      din_s1  <= link.din;
      din_s2  <= din_s1;
    end
  end

  logic sclk_fall, sclk_rise, cs_fall;
  assign sclk_fall = sclk_s3 && !sclk_s2;
  assign sclk_rise = !sclk_s3 && sclk_s2;
  assign cs_fall   = cs_s3 && !cs_s2;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  srap_dev_state_t state, next_state;
  logic [4:0]  cnt, next_cnt;
  logic [4:0]  dbits, next_dbits;
  logic [15:0] sh, next_sh;
  logic [4:0]  addr, next_addr;
  logic        two, next_two;
  logic        dout_q, next_dout;
  logic        oe_q, next_oe;
  logic        cv, next_cv;
  logic        chi, next_chi;
  logic [4:0]  caddr, next_caddr;
  logic [7:0]  cbyte, next_cbyte;
  logic [15:0] regs [`SRAP_NUM_REGS];
  logic [7:0]  cmd_byte;
  logic [3:0]  wcode;

  assign cmd_byte = {sh[6:0], din_s2};
  assign wcode    = REG_WCODE[cmd_byte[`SRAP_ADDR_BITS-1:0]*`SRAP_WCODE_BITS +: `SRAP_WCODE_BITS];

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_dbits = dbits;
    next_sh    = sh;
    next_addr  = addr;
    next_two   = two;
    next_dout  = dout_q;
    next_oe    = oe_q;
    next_cv    = 1'b0;
    next_chi   = chi;
    next_caddr = caddr;
    next_cbyte = cbyte;
    if (cs_s2 || cs_fall) begin
      // Deselect aborts whatever was under way; a partial byte is dropped.
      next_state = SRAP_D_CMD;
      next_cnt   = '0;
      next_oe    = 1'b0;
    end else begin
      unique case (state)
        SRAP_D_CMD: begin
          if (sclk_fall) begin
            next_sh  = {sh[14:0], din_s2};
            next_cnt = cnt + 5'd1;
            if (cnt == 5'(`SRAP_CMD_BITS - 1)) begin
              next_cnt   = '0;
              next_addr  = cmd_byte[`SRAP_ADDR_BITS-1:0];
              next_two   = wcode[3];
              next_dbits = wcode[3] ? 5'd16 : 5'd8;
              if (cmd_byte[`SRAP_DIR_BIT] == `SRAP_DIR_WRITE) begin
                next_state = SRAP_D_WR;
              end else begin
                // The whole register is frozen here, so later bank updates
                // cannot tear a value that is half shifted out.
                next_sh    = wcode[3] ? regs[next_addr]
                           : {regs[next_addr][7:0], 8'h00};
                next_state = SRAP_D_RD;
              end
            end
          end
        end
        SRAP_D_WR: begin
          if (sclk_fall) begin
            next_sh  = {sh[14:0], din_s2};
            next_cnt = cnt + 5'd1;
            if (cnt[2:0] == 3'd7) begin
              // Only a byte with all eight bits in is handed to the bank.
              next_cv    = 1'b1;
              next_chi   = two && !cnt[3];
              next_caddr = addr;
              next_cbyte = {sh[6:0], din_s2};
            end
            if (cnt == dbits - 5'd1) begin
              next_cnt   = '0;
              next_state = SRAP_D_CMD;
            end
          end
        end
        SRAP_D_RD: begin
          if (sclk_rise && cnt != dbits) begin
            next_oe   = 1'b1;
            next_dout = sh[15];
            next_sh   = {sh[14:0], 1'b0};
            next_cnt  = cnt + 5'd1;
          end
          if (sclk_fall && cnt == dbits) begin
            next_oe    = 1'b0;
            next_cnt   = '0;
            next_state = SRAP_D_CMD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state  <= SRAP_D_CMD;
      cnt    <= '0;
      dbits  <= '0;
      sh     <= '0;
      addr   <= '0;
      two    <= 1'b0;
      dout_q <= 1'b0;
      oe_q   <= 1'b0;
      cv     <= 1'b0;
      chi    <= 1'b0;
      caddr  <= '0;
      cbyte  <= '0;
    end else if (ce) begin
      state  <= next_state;
      cnt    <= next_cnt;
      dbits  <= next_dbits;
      sh     <= next_sh;
      addr   <= next_addr;
      two    <= next_two;
      dout_q <= next_dout;
      oe_q   <= next_oe;
      cv     <= next_cv;
      chi    <= next_chi;
      caddr  <= next_caddr;
      cbyte  <= next_cbyte;
    end
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  logic [15:0] next_regs [`SRAP_NUM_REGS];
  logic [15:0] cmask;
  logic        next_wr_pulse;

  // Bits above the register's width are dropped on the way in.
  assign cmask = 16'hFFFF >> (4'hF - REG_WCODE[caddr*`SRAP_WCODE_BITS +: `SRAP_WCODE_BITS]);

  always_comb begin
    next_regs = regs;
    if (upd_en) begin
      next_regs[upd_addr] = upd_data;
    end
    // The byte was completed in this domain one cycle earlier and is held
    // stable in its own register, so the bank sees a settled value.
    if (cv) begin
      if (chi) begin
        next_regs[caddr][15:8] = cbyte & cmask[15:8];
      end else begin
        next_regs[caddr][7:0]  = cbyte & cmask[7:0];
      end
    end
    next_wr_pulse = cv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `SRAP_NUM_REGS; i++) begin
        regs[i] <= `SRAP_REG_RESET;
      end
      wr_pulse <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
    end else if (ce) begin
      regs     <= next_regs;
      wr_pulse <= next_wr_pulse;
      wr_addr  <= caddr;
      wr_data  <= next_regs[caddr];
    end
  end

  assign link.dout    = dout_q;
  assign link.dout_oe = oe_q;

endmodule : srap_device

`default_nettype wire

/* File: design/srap_host.sv */
// Host end: a serial bus master steered through Avalon-MM registers.
// Assumes a device end on the same link and a 40 MHz clock.
`include "srap_params.svh"
`default_nettype none

module srap_host
  import srap_pkg::*;
#(
  parameter int HALF_CYC = `SRAP_HALF_CYC
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial link
  srap_if.host             link
);

  // ----------------------------------------------------------------
  // Checks and constants
  // ----------------------------------------------------------------
  // The data-out sample lands on the same edge as the fall; faster
  // settings below that would miss the device's three-cycle delay plus our two.
  if (HALF_CYC < `SRAP_HALF_MIN || HALF_CYC > 255) begin : g_bad_half
    $error("srap_host: HALF_CYC out of range");
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
  localparam logic [7:0] GAP_LAST  = 8'(`SRAP_GAP_CYC - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  srap_host_state_t state, next_state;
  logic [7:0]  hc, next_hc;
  logic [4:0]  bc, next_bc;
  logic [4:0]  nbits, next_nbits;
  logic [23:0] tx, next_tx;
  logic [15:0] rx, next_rx;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic [7:0]  cmd, next_cmd;
  logic        two, next_two;
  logic        sclk_q, next_sclk;
  logic        cs_q, next_cs;
  logic        din_q, next_din;
  logic        wait_q, next_wait;
  logic [31:0] rd_q, next_rd;
  logic        dout_s1, dout_s2;
  logic        busy;

  assign busy = (state != SRAP_H_IDLE);

  always_comb begin
    next_state = state;
    next_hc    = hc;
    next_bc    = bc;
    next_nbits = nbits;
    next_tx    = tx;
    next_rx    = rx;
    next_wdata = wdata;
    next_rdata = rdata;
    next_cmd   = cmd;
    next_two   = two;
    next_sclk  = sclk_q;
    next_cs    = cs_q;
    next_din   = din_q;
    next_rd    = rd_q;
    // Waitrequest drops for exactly one cycle after a request is seen.
    next_wait  = !((avs_read || avs_write) && wait_q);
    if (avs_read && wait_q) begin
      unique case (avs_address)
        `SRAP_OFS_CMD:   next_rd = {1'b0, busy, 20'h0_0000, two, cmd[`SRAP_DIR_BIT],
                                    3'h0, cmd[`SRAP_ADDR_BITS-1:0]};
        `SRAP_OFS_WDATA: next_rd = {16'h0000, wdata};
        `SRAP_OFS_RDATA: next_rd = {16'h0000, rdata};
        default:         next_rd = 32'h0000_0000;
      endcase
    end
    if (avs_write && !wait_q) begin
      if (avs_address == `SRAP_OFS_WDATA) begin
        next_wdata = avs_writedata[15:0];
      end
    end
    unique case (state)
      SRAP_H_IDLE: begin
        next_sclk = 1'b1;
        next_cs   = 1'b1;
        if (avs_write && !wait_q && avs_address == `SRAP_OFS_CMD && avs_writedata[`SRAP_CTL_GO]) begin
          // Command byte: direction in the top bit, address in the low five.
          next_cmd   = {avs_writedata[`SRAP_CTL_DIR], 2'b00,
                        avs_writedata[`SRAP_ADDR_BITS-1:0]};
          next_two   = avs_writedata[`SRAP_CTL_TWO];
          next_tx    = {next_cmd, avs_writedata[`SRAP_CTL_TWO] ? wdata
                                  : {wdata[7:0], 8'h00}};
          next_nbits = avs_writedata[`SRAP_CTL_TWO] ? 5'd24 : 5'd16;
          next_din   = next_cmd[`SRAP_DIR_BIT];
          next_cs    = 1'b0;
          next_bc    = '0;
          next_hc    = '0;
          next_rx    = '0;
          next_state = SRAP_H_HIGH;
        end
      end
      SRAP_H_HIGH: begin
        next_hc = hc + 8'd1;
        if (hc == HALF_LAST) begin
          if (!cmd[`SRAP_DIR_BIT] && bc >= 5'(`SRAP_CMD_BITS)) begin
            next_rx = {rx[14:0], dout_s2};
          end
          next_sclk  = 1'b0;
          next_hc    = '0;
          next_state = SRAP_H_LOW;
        end
      end
      SRAP_H_LOW: begin
        next_hc = hc + 8'd1;
        if (hc == HALF_LAST) begin
          next_sclk = 1'b1;
          next_hc   = '0;
          next_bc   = bc + 5'd1;
          next_tx   = {tx[22:0], 1'b0};
          next_din  = tx[22];
          if (cmd[`SRAP_DIR_BIT] && next_bc[2:0] == 3'd0 && next_bc >= 5'd16) begin
            next_state = SRAP_H_GAP;
          end else if (next_bc == nbits) begin
            // A started transfer always runs to its last bit.
            next_cs    = 1'b1;
            next_rdata = rx;
            next_state = SRAP_H_IDLE;
          end else begin
            next_state = SRAP_H_HIGH;
          end
        end
      end
      SRAP_H_GAP: begin
        next_hc = hc + 8'd1;
        if (hc == GAP_LAST) begin
          next_hc    = '0;
          next_cs    = (bc == nbits);
          next_state = (bc == nbits) ? SRAP_H_IDLE : SRAP_H_HIGH;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= SRAP_H_IDLE;
      hc      <= '0;
      bc      <= '0;
      nbits   <= '0;
      tx      <= '0;
      rx      <= '0;
      wdata   <= '0;
      rdata   <= '0;
      cmd     <= '0;
      two     <= 1'b0;
      sclk_q  <= 1'b1;
      cs_q    <= 1'b1;
      din_q   <= 1'b0;
      wait_q  <= 1'b1;
      rd_q    <= '0;
      dout_s1 <= 1'b0;
      dout_s2 <= 1'b0;
    end else if (ce) begin
      state   <= next_state;
      hc      <= next_hc;
      bc      <= next_bc;
      nbits   <= next_nbits;
      tx      <= next_tx;
      rx      <= next_rx;
      wdata   <= next_wdata;
      rdata   <= next_rdata;
      cmd     <= next_cmd;
      two     <= next_two;
      sclk_q  <= next_sclk;
      cs_q    <= next_cs;
      din_q   <= next_din;
      wait_q  <= next_wait;
      rd_q    <= next_rd;
      dout_s1 <= link.dout;
      dout_s2 <= dout_s1;
    end
  end

  assign link.sclk       = sclk_q;
  assign link.cs_n       = cs_q;
  assign link.din        = din_q;
  assign avs_readdata    = rd_q;
  assign avs_waitrequest = wait_q;

endmodule : srap_host

`default_nettype wire

/* File: design/srap_if.sv */
// Four-wire serial link between the host and the register port.
// Assumes the bench resolves the data-out wire from its enable.
`default_nettype none

interface srap_if;

  // ----------------------------------------------------------------
  // Link signals
  // ----------------------------------------------------------------
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic dout_oe;

  modport device (
    input  sclk,
    input  cs_n,
    input  din,
    output dout,
    output dout_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output din,
    input  dout,
    input  dout_oe
  );

endinterface : srap_if

`default_nettype wire

/* File: design/srap_params.svh */
// Constants shared by both ends of the serial register access port.
// Assumes a 40 MHz system clock at each end; included by bare name.
`ifndef SRAP_PARAMS_SVH
`define SRAP_PARAMS_SVH

// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define SRAP_CMD_BITS   8
`define SRAP_DIR_BIT    7
`define SRAP_ADDR_BITS  5
`define SRAP_BYTE_BITS  8
`define SRAP_DATA_BITS  16
`define SRAP_NUM_REGS   32
`define SRAP_WCODE_BITS 4
`define SRAP_DIR_WRITE  1'b1
`define SRAP_REG_RESET  16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SRAP_CLK_NS     25
`define SRAP_GAP_NS     4000
`define SRAP_GAP_CYC    ((`SRAP_GAP_NS + `SRAP_CLK_NS - 1) / `SRAP_CLK_NS)
`define SRAP_HALF_CYC   8
`define SRAP_HALF_MIN   6

// ----------------------------------------------------------------
// Host register map (byte addresses) and fields
// ----------------------------------------------------------------
`define SRAP_OFS_CMD    4'h0
`define SRAP_OFS_WDATA  4'h4
`define SRAP_OFS_RDATA  4'h8
`define SRAP_CTL_GO     31
`define SRAP_CTL_BUSY   30
`define SRAP_CTL_TWO    9
`define SRAP_CTL_DIR    8

`endif

/* File: design/srap_pkg.sv */
// Types shared by both ends of the serial register access port.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package srap_pkg;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRAP_D_CMD = 3'b001,
    SRAP_D_WR  = 3'b010,
    SRAP_D_RD  = 3'b100
  } srap_dev_state_t;

  typedef enum logic [3:0] {
    SRAP_H_IDLE = 4'b0001,
    SRAP_H_HIGH = 4'b0010,
    SRAP_H_LOW  = 4'b0100,
    SRAP_H_GAP  = 4'b1000
  } srap_host_state_t;

endpackage : srap_pkg

`default_nettype wire

/* File: test/srap_link_monitor.sv */
// Checker for the four-wire link between the host and device ends.
// Assumes both ends and this checker share one clock and a synchronous reset.
`default_nettype none

module srap_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic        sclk_q, next_sclk_q;
  logic [4:0]  fcnt, next_fcnt;
  logic        wdir, next_wdir;
  logic [11:0] since, next_since;
  logic        fall;

  // Counts serial clock falls inside a frame and cycles since a write byte ended.
  assign fall = sclk_q && !sclk && !cs_n;

  always_comb begin
    next_sclk_q = sclk;
    next_fcnt   = cs_n ? 5'h00 : fcnt + 5'(fall);
    next_wdir   = (fall && fcnt == 5'h00) ? din : wdir;
    next_since  = (since == 12'hFFF) ? since : since + 12'h001;
    if (fall && wdir && (fcnt == 5'h0F || fcnt == 5'h17))
      next_since = 12'h000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_q <= 1'b1;
      fcnt   <= 5'h00;
      wdir   <= 1'b0;
      since  <= 12'hFFF;
    end else begin
      sclk_q <= next_sclk_q;
      fcnt   <= next_fcnt;
      wdir   <= next_wdir;
      since  <= next_since;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cs_float; cs_n [*5] |-> !dout_oe; endproperty
  property p_dout_rise; $changed(dout) && dout_oe && $past(dout_oe) |-> $past(sclk, 3); endproperty
  property p_oe_rise; $rose(dout_oe) |-> $past(sclk, 3); endproperty
  property p_oe_read; $rose(dout_oe) |-> fcnt == 5'h08 && !wdir; endproperty
  property p_oe_off; $fell(dout_oe) |-> $past(cs_n, 3) || !$past(sclk, 3); endproperty
  property p_no_oe_wr; !cs_n && wdir && fcnt != 5'h00 |-> !dout_oe; endproperty
  property p_din_hold; $changed(din) && !cs_n |-> sclk; endproperty
  property p_cs_rise; $rose(cs_n) |-> sclk && (fcnt == 5'h10 || fcnt == 5'h18); endproperty
  property p_byte_gap; fall && (fcnt == 5'h07 || fcnt == 5'h0F || fcnt == 5'h17) |-> since >= 12'h09F; endproperty

  a_cs_float: assert property (p_cs_float) else $error("data out driven while select high");
  a_dout_rise: assert property (p_dout_rise) else $error("data out moved away from a rise");
  a_oe_rise: assert property (p_oe_rise) else $error("data out enabled away from a rise");
  a_oe_read: assert property (p_oe_read) else $error("data out enabled outside a read");
  a_oe_off: assert property (p_oe_off) else $error("data out released at a wrong moment");
  a_no_oe_wr: assert property (p_no_oe_wr) else $error("data out driven during a write");
  a_din_hold: assert property (p_din_hold) else $error("data in moved while clock low");
  a_cs_rise: assert property (p_cs_rise) else $error("select raised mid transfer");
  a_byte_gap: assert property (p_byte_gap) else $error("byte ended too soon after write byte");

  c_read: cover property ($rose(dout_oe));
  c_two_byte_write: cover property (fall && wdir && fcnt == 5'h17);
  c_frame_end: cover property ($rose(cs_n));

endmodule : srap_link_monitor

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench: host and device ends joined over one link.
// Assumes the host register map and timing of the shared parameter header.
`include "srap_params.svh"
`default_nettype none

module tb;
  import srap_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // Address 7 is 12 bits wide and address 8 is 6 bits wide; the rest are 16 bits.
  localparam logic [127:0] WCODE = {{23{4'hF}}, 4'h5, 4'hB, {7{4'hF}}};

  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic        clk;
  logic        rst             = 1'b1;
  logic        ce              = 1'b1;
  logic [3:0]  avs_address     = 4'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        upd_en          = 1'b0;
  logic [4:0]  upd_addr        = 5'h00;
  logic [15:0] upd_data        = 16'h0000;
  logic        wr_pulse;
  logic [4:0]  wr_addr;
  logic [15:0] wr_data;
  logic [15:0] mreg [32]       = '{default: 16'h0000};
  logic [20:0] wq [$];
  logic [23:0] din_sh          = 24'h00_0000;
  logic [15:0] dout_sh         = 16'h0000;
  logic        sclk_d          = 1'b1;
  logic        cs_d            = 1'b1;
  int          nbits           = 0;
  int          failures        = 0;
  int          n_compared      = 0;
  int          seed            = 42726;

  srap_if srap_if_inst ();

  srap_host #(.HALF_CYC(8)) srap_host_inst (
    .clk(clk), .rst(rst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(srap_if_inst)
  );

  srap_device #(.REG_WCODE(WCODE)) srap_device_inst (
    .clk(clk), .rst(rst), .ce(ce), .link(srap_if_inst), .upd_en(upd_en), .upd_addr(upd_addr),
    .upd_data(upd_data), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data)
  );

  srap_link_monitor srap_link_monitor_inst (
    .clk(clk), .rst(rst), .sclk(srap_if_inst.sclk), .cs_n(srap_if_inst.cs_n),
    .din(srap_if_inst.din), .dout(srap_if_inst.dout), .dout_oe(srap_if_inst.dout_oe)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Wire watcher: both lines are sampled on serial clock falls, as the device does.
  always @(posedge clk) begin
    sclk_d <= srap_if_inst.sclk;
    cs_d   <= srap_if_inst.cs_n;
    if (cs_d && !srap_if_inst.cs_n) begin
      nbits <= 0;
    end else if (sclk_d && !srap_if_inst.sclk && !srap_if_inst.cs_n) begin
      nbits   <= nbits + 1;
      din_sh  <= {din_sh[22:0], srap_if_inst.din};
      dout_sh <= {dout_sh[14:0], srap_if_inst.dout};
    end
    if (wr_pulse === 1'b1)
      wq.push_back({wr_addr, wr_data});
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [3:0] wcode(input logic [4:0] a);
    return WCODE[a * 4 +: 4];
  endfunction : wcode

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    // The request stands until waitrequest is seen low; only the watchdog ends a hung wait.
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk("waitrequest", 32'h0000_0000, 32'(avs_waitrequest));
  endtask : av

  task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d, output logic [31:0] q);
    av(1'b1, `SRAP_OFS_WDATA, {16'h0000, d}, q);
    av(1'b1, `SRAP_OFS_CMD, {1'b1, 21'h0, wcode(a) >= 4'h8, wr, 3'h0, a}, q);
    do begin
      av(1'b0, `SRAP_OFS_CMD, 32'h0000_0000, q);
    end while (q[`SRAP_CTL_BUSY] !== 1'b0);
    if (!wr)
      av(1'b0, `SRAP_OFS_RDATA, 32'h0000_0000, q);
  endtask : xfer

  task automatic wr_chk(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    logic [15:0] m;
    logic        two;
    m   = 16'hFFFF >> (5'd15 - 5'(wcode(a)));
    two = wcode(a) >= 4'h8;
    wq.delete();
    xfer(1'b1, a, d, q);
    chk("commit count", two ? 32'd2 : 32'd1, 32'(wq.size()));
    if (two && wq.size() > 0)
      chk("upper byte commit", 32'({a, ((d & 16'hFF00) | (mreg[a] & 16'h00FF)) & m}),
          32'(wq.pop_front()));
    mreg[a] = (two ? d : {8'h00, d[7:0]}) & m;
    if (wq.size() > 0)
      chk("last byte commit", 32'({a, mreg[a]}), 32'(wq.pop_front()));
    chk("din stream", two ? 32'({1'b1, 2'b00, a, d}) : 32'({1'b1, 2'b00, a, d[7:0]}),
        two ? 32'(din_sh) : 32'(din_sh[15:0]));
    chk("write bit count", two ? 32'd24 : 32'd16, 32'(nbits));
  endtask : wr_chk

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [31:0] q;
    logic        two;
    two = wcode(a) >= 4'h8;
    xfer(1'b0, a, 16'h0000, q);
    chk("read data", 32'(e), q);
    chk("dout stream", 32'(e), two ? 32'(dout_sh) : 32'(dout_sh[7:0]));
    chk("read bit count", two ? 32'd24 : 32'd16, 32'(nbits));
  endtask : rd_chk

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [4:0]  a;
    logic [15:0] d;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(5'h06, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      a = (i == 0) ? 5'h07 : (i == 1) ? 5'h08 : (i == 2) ? 5'h1F : 5'($random(seed));
      d = 16'($random(seed));
      wr_chk(a, d);
      rd_chk(a, mreg[a]);
    end
    // An internal update lands mid read; the read must return the old value.
    d = 16'($random(seed));
    fork
      rd_chk(5'h03, mreg[3]);
      begin
        repeat (200) @(posedge clk);
        upd_en   <= 1'b1;
        upd_addr <= 5'h03;
        upd_data <= d;
        @(posedge clk);
        upd_en <= 1'b0;
      end
    join
    mreg[3] = d;
    rd_chk(5'h03, d);
    wrap_up();
  end

  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    wrap_up();
  end

endmodule : tb

`default_nettype wire
